// ---- rtl/ofd_top.sv ----
// Summary of operation
// - no-sib 32-bit: base from r/m, mod-sized displacement
// - r/m100 non-register fetches sib, scale 1/2/4/8
// - 16-bit register operands, byte regs for w=0
// - 32-bit register operands, same byte mapping
// - index code 100 means no index
// - sib base101 mod00: dword displacement, no base
// - sib base100 uses stack pointer, stack segment
// - sib base101 mod01/10: frame base, stack segment
// - sib adds byte/dword displacement by mod
// - direction bit swaps source and destination
// - sign-extend 8-bit immediate into wider destination
// - low condition bit negates selected condition
// - selectors 0-3: overflow, below, zero, below-equal
// - selectors 4-7: sign, parity, less, less-equal
// - 32-bit tables only under 32-bit addressing
//
// The implementer's own choices: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module ofd_top
    import ofd_pkg::*;
(
    input wire logic REF_CLK,
    input wire logic RST_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    output logic EA_BASE_VALID,
    output logic [2:0] EA_BASE_REG,
    output logic EA_INDEX_VALID,
    output logic [2:0] EA_INDEX_REG,
    output logic [1:0] EA_SCALE,
    output logic [31:0] EA_DISP,
    output logic EA_STACK_SEG,
    output logic EA_UNDEFINED,
    output logic SIB_NEEDED,
    output logic OPND_IS_REG,
    output logic [2:0] DST_REG,
    output logic DST_HIGH_BYTE,
    output logic DST_IN_MEM,
    output logic [2:0] SRC_REG,
    output logic SRC_HIGH_BYTE,
    output logic SRC_IN_MEM,
    output logic [1:0] OPND_WIDTH,
    output logic [31:0] IMM_DATA,
    output logic COND_TRUE
);

    // ********************************************************
    // software registers
    // ********************************************************
    logic [5:0] ctrl;
    logic [19:0] insn;
    logic [31:0] disp_raw;
    logic [31:0] imm_raw;
    logic [4:0] flags;
    logic [31:0] rd_data;

    // ********************************************************
    // apb decode
    // ********************************************************
    wire hit_ctrl = PADDR == OFD_OFF_CTRL;
    wire hit_insn = PADDR == OFD_OFF_INSN;
    wire hit_disp = PADDR == OFD_OFF_DISP;
    wire hit_imm = PADDR == OFD_OFF_IMM;
    wire hit_flags = PADDR == OFD_OFF_FLAGS;
    wire hit_dec_ea = PADDR == OFD_OFF_DEC_EA;
    wire hit_dec_opnd = PADDR == OFD_OFF_DEC_OPND;
    wire hit_ea_disp = PADDR == OFD_OFF_EA_DISP;
    wire hit_imm_ext = PADDR == OFD_OFF_IMM_EXT;
    wire addr_ok = hit_ctrl | hit_insn | hit_disp | hit_imm | hit_flags
        | hit_dec_ea | hit_dec_opnd | hit_ea_disp | hit_imm_ext;

    // writes land at the access edge; read data is caught one edge earlier
    wire wr_en = PSEL & PENABLE & PWRITE & addr_ok;
    wire rd_setup = PSEL & ~PENABLE & ~PWRITE;

    // zero wait states; unmapped addresses answer with an error
    assign PREADY = 1'b1;
    assign PSLVERR = PSEL & PENABLE & ~addr_ok;

    // ********************************************************
    // control word and instruction fields
    // ********************************************************
    wire addr32 = ctrl[OFD_CTRL_ADDR32];
    wire opsize32 = ctrl[OFD_CTRL_OPSIZE32];
    wire wbit = ctrl[OFD_CTRL_WBIT];
    wire dbit = ctrl[OFD_CTRL_DIR];
    wire sbit = ctrl[OFD_CTRL_SEXT];
    wire imm8 = ctrl[OFD_CTRL_IMM8];

    wire [1:0] f_mod = insn[OFD_MOD_LSB +: 2];
    wire [2:0] f_reg = insn[OFD_REG_LSB +: 3];
    wire [2:0] f_rm = insn[OFD_RM_LSB +: 3];
    wire [1:0] f_ss = insn[OFD_SS_LSB +: 2];
    wire [2:0] f_idx = insn[OFD_IDX_LSB +: 3];
    wire [2:0] f_base = insn[OFD_BASE_LSB +: 3];
    wire [3:0] f_tttn = insn[OFD_TTTN_LSB +: 4];

    // a memory operand is any mod other than the register form
    wire mod_mem = f_mod != OFD_MOD_REG;
    wire mod_none = f_mod == OFD_MOD_NODISP;
    wire mod_byte = f_mod == OFD_MOD_DISP8;
    wire mod_dword = f_mod == OFD_MOD_DISP32;

    // ********************************************************
    // 32-bit addressing form
    // ********************************************************
    // sib only follows r/m 100 in a memory form
    wire a32_sib = mod_mem & (f_rm == OFD_RM_SIB);
    // mod 00 r/m 101 carries an absolute dword displacement
    wire a32_abs = mod_none & (f_rm == OFD_RM_ABS);
    // sib base 101 under mod 00 drops the base register
    wire a32_sib_abs = a32_sib & mod_none & (f_base == OFD_RM_ABS);

    // base comes from sib base field or from r/m
    wire [2:0] a32_base_reg = a32_sib ? f_base : f_rm;
    wire a32_base_valid = mod_mem & ~a32_abs & ~a32_sib_abs;

    // index code 100 means no index, so the scaled term is zero
    wire a32_index_valid = a32_sib & (f_idx != OFD_IDX_NONE);

    // stack segment whenever the base is the stack or frame pointer
    wire a32_stack = a32_base_valid
        & ((a32_base_reg == OFD_STACK_POINTER_REG)
        | (a32_base_reg == OFD_FRAME_BASE_REG));

    // displacement size follows mod, absolute forms use a dword
    wire [1:0] a32_dsz = mod_byte ? OFD_DSZ_BYTE
        : mod_dword ? OFD_DSZ_DWORD
        : (a32_abs | a32_sib_abs) ? OFD_DSZ_DWORD
        : OFD_DSZ_NONE;

    // only flagged: the address is undefined, the hardware still decodes
    wire a32_undef = a32_sib & (f_idx == OFD_IDX_NONE) & (f_ss != OFD_SS_X1);

    // ********************************************************
    // 16-bit addressing form
    // ********************************************************
    // r/m 110 under mod 00 is an absolute word displacement
    wire a16_abs = mod_none & (f_rm == OFD_RM16_ABS);
    wire a16_bp = (f_rm == 3'h2) | (f_rm == 3'h3) | (f_rm == OFD_RM16_ABS);
    wire a16_no_base = (f_rm == 3'h4) | (f_rm == 3'h5);
    wire a16_base_valid = mod_mem & ~a16_no_base & ~a16_abs;
    wire [2:0] a16_base_reg = a16_bp ? OFD_FRAME_BASE_REG : OFD_BX_REG;
    wire a16_index_valid = mod_mem & (f_rm < OFD_RM16_ABS);
    wire [2:0] a16_index_reg = f_rm[0] ? OFD_DI_REG : OFD_SI_REG;
    wire a16_stack = a16_base_valid & a16_bp;
    wire [1:0] a16_dsz = mod_byte ? OFD_DSZ_BYTE
        : mod_dword ? OFD_DSZ_WORD
        : a16_abs ? OFD_DSZ_WORD
        : OFD_DSZ_NONE;

    // ********************************************************
    // addressing width select
    // ********************************************************
    // the 32-bit tables apply only while 32-bit addressing is on
    wire ea_base_valid = addr32 ? a32_base_valid : a16_base_valid;
    wire [2:0] ea_base_reg = addr32 ? a32_base_reg : a16_base_reg;
    wire ea_index_valid = addr32 ? a32_index_valid : a16_index_valid;
    wire [2:0] ea_index_reg = addr32 ? f_idx : a16_index_reg;
    wire [1:0] ea_scale = (addr32 & a32_sib) ? f_ss : OFD_SS_X1;
    wire [1:0] ea_dsz = addr32 ? a32_dsz : a16_dsz;
    wire ea_stack = addr32 ? a32_stack : a16_stack;
    wire ea_undef = addr32 & a32_undef;
    wire sib_needed = addr32 & a32_sib;

    // displacement extended to 32 bits; 16-bit adders just use the low half
    wire [31:0] disp_ext = (ea_dsz == OFD_DSZ_BYTE) ? {{24{disp_raw[7]}}, disp_raw[7:0]}
        : (ea_dsz == OFD_DSZ_WORD) ? {{16{disp_raw[15]}}, disp_raw[15:0]}
        : (ea_dsz == OFD_DSZ_DWORD) ? disp_raw
        : OFD_WORD_RST;

    // ********************************************************
    // register operands
    // ********************************************************
    // entry 0 is the reg field, entry 1 the r/m field
    wire [2:0] opnd_code [2];
    logic [2:0] opnd_num [2];
    logic opnd_hi [2];

    assign opnd_code[0] = f_reg;
    assign opnd_code[1] = f_rm;

    // byte form maps codes 100-111 onto the high bytes of registers 0-3
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_opnd
            assign opnd_num[gi] = wbit ? opnd_code[gi] : {1'b0, opnd_code[gi][1:0]};
            assign opnd_hi[gi] = ~wbit & opnd_code[gi][2];
        end
    endgenerate

    // w selects full width; data width decides word or dword
    wire [1:0] opnd_width = ~wbit ? OFD_WID_BYTE
        : opsize32 ? OFD_WID_DWORD
        : OFD_WID_WORD;

    // direction bit 1 makes the reg field the destination
    wire [2:0] dst_num = dbit ? opnd_num[0] : opnd_num[1];
    wire dst_hi = dbit ? opnd_hi[0] : opnd_hi[1];
    wire [2:0] src_num = dbit ? opnd_num[1] : opnd_num[0];
    wire src_hi = dbit ? opnd_hi[1] : opnd_hi[0];
    wire dst_mem = ~dbit & mod_mem;
    wire src_mem = dbit & mod_mem;

    // ********************************************************
    // immediate data
    // ********************************************************
    // sign extension only for a byte immediate into a wider target
    wire imm_sext = sbit & imm8 & (opnd_width != OFD_WID_BYTE);
    wire [31:0] imm_ext = imm_sext ? {{24{imm_raw[7]}}, imm_raw[7:0]}
        : (imm8 | (opnd_width == OFD_WID_BYTE)) ? {24'h000000, imm_raw[7:0]}
        : (opnd_width == OFD_WID_WORD) ? {16'h0000, imm_raw[15:0]}
        : imm_raw;

    // ********************************************************
    // condition test
    // ********************************************************
    logic cond_true;

    ofd_cond_eval u_cond (
        .tttn(f_tttn),
        .flags(flags),
        .cond_true(cond_true)
    );

    // ********************************************************
    // status words
    // ********************************************************
    // status reads see the combinational decode, so a read right after a write is fresh
    wire [31:0] dec_ea_word = {16'h0000, ea_undef, ~mod_mem, sib_needed, ea_stack,
        ea_dsz, ea_scale, ea_index_reg, ea_index_valid, ea_base_reg, ea_base_valid};
    wire [31:0] dec_opnd_word = {18'h00000, cond_true, imm_sext, src_mem, dst_mem,
        opnd_width, src_hi, src_num, dst_hi, dst_num};

    // read mux; unmapped reads return zero
    wire [31:0] rd_mux = hit_ctrl ? {26'h0000000, ctrl}
        : hit_insn ? {12'h000, insn}
        : hit_disp ? disp_raw
        : hit_imm ? imm_raw
        : hit_flags ? {27'h0000000, flags}
        : hit_dec_ea ? dec_ea_word
        : hit_dec_opnd ? dec_opnd_word
        : hit_ea_disp ? disp_ext
        : hit_imm_ext ? imm_ext
        : OFD_WORD_RST;

    // ********************************************************
    // register writes
    // ********************************************************
    // control and instruction registers
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            ctrl <= OFD_CTRL_RST;
            insn <= OFD_INSN_RST;
        end else if (wr_en) begin
            if (hit_ctrl) begin
                ctrl <= PWDATA[OFD_CTRL_W-1:0];
            end
            if (hit_insn) begin
                insn <= PWDATA[19:0];
            end
        end
    end

    // displacement, immediate and flags registers
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            disp_raw <= OFD_WORD_RST;
            imm_raw <= OFD_WORD_RST;
            flags <= OFD_FLAGS_RST;
        end else if (wr_en) begin
            if (hit_disp) begin
                disp_raw <= PWDATA;
            end
            if (hit_imm) begin
                imm_raw <= PWDATA;
            end
            if (hit_flags) begin
                flags <= PWDATA[4:0];
            end
        end
    end

    // read data is latched in the setup cycle and held through access
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            rd_data <= OFD_WORD_RST;
        end else if (rd_setup) begin
            rd_data <= rd_mux;
        end
    end

    assign PRDATA = rd_data;

    // ********************************************************
    // registered decode outputs
    // ********************************************************
    // address side; one cycle behind the registers to keep the adder path short
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            EA_BASE_VALID <= 1'b0;
            EA_BASE_REG <= 3'h0;
            EA_INDEX_VALID <= 1'b0;
            EA_INDEX_REG <= 3'h0;
            EA_SCALE <= OFD_SS_X1;
            EA_DISP <= OFD_WORD_RST;
            EA_STACK_SEG <= 1'b0;
            EA_UNDEFINED <= 1'b0;
            SIB_NEEDED <= 1'b0;
        end else begin
            EA_BASE_VALID <= ea_base_valid;
            EA_BASE_REG <= ea_base_reg;
            EA_INDEX_VALID <= ea_index_valid;
            EA_INDEX_REG <= ea_index_reg;
            EA_SCALE <= ea_scale;
            EA_DISP <= disp_ext;
            EA_STACK_SEG <= ea_stack;
            EA_UNDEFINED <= ea_undef;
            SIB_NEEDED <= sib_needed;
        end
    end

    // operand side towards the execution unit
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            OPND_IS_REG <= 1'b0;
            DST_REG <= 3'h0;
            DST_HIGH_BYTE <= 1'b0;
            DST_IN_MEM <= 1'b0;
            SRC_REG <= 3'h0;
            SRC_HIGH_BYTE <= 1'b0;
            SRC_IN_MEM <= 1'b0;
            OPND_WIDTH <= OFD_WID_BYTE;
            IMM_DATA <= OFD_WORD_RST;
            COND_TRUE <= 1'b0;
        end else begin
            OPND_IS_REG <= ~mod_mem;
            DST_REG <= dst_num;
            DST_HIGH_BYTE <= dst_hi;
            DST_IN_MEM <= dst_mem;
            SRC_REG <= src_num;
            SRC_HIGH_BYTE <= src_hi;
            SRC_IN_MEM <= src_mem;
            OPND_WIDTH <= opnd_width;
            IMM_DATA <= imm_ext;
            COND_TRUE <= cond_true;
        end
    end

endmodule

`default_nettype wire

// ---- rtl/ofd_pkg.sv ----
package ofd_pkg;

    // ********************************************************
    // register offsets (byte addresses, one aligned word each)
    // ********************************************************
    localparam logic [7:0] OFD_OFF_CTRL = 8'h00;
    localparam logic [7:0] OFD_OFF_INSN = 8'h04;
    localparam logic [7:0] OFD_OFF_DISP = 8'h08;
    localparam logic [7:0] OFD_OFF_IMM = 8'h0C;
    localparam logic [7:0] OFD_OFF_FLAGS = 8'h10;
    localparam logic [7:0] OFD_OFF_DEC_EA = 8'h14;
    localparam logic [7:0] OFD_OFF_DEC_OPND = 8'h18;
    localparam logic [7:0] OFD_OFF_EA_DISP = 8'h1C;
    localparam logic [7:0] OFD_OFF_IMM_EXT = 8'h20;

    // ********************************************************
    // control word bits and reset values
    // ********************************************************
    localparam int OFD_CTRL_ADDR32 = 0;
    localparam int OFD_CTRL_OPSIZE32 = 1;
    localparam int OFD_CTRL_WBIT = 2;
    localparam int OFD_CTRL_DIR = 3;
    localparam int OFD_CTRL_SEXT = 4;
    localparam int OFD_CTRL_IMM8 = 5;
    localparam int OFD_CTRL_W = 6;
    localparam logic [5:0] OFD_CTRL_RST = 6'h00;
    localparam logic [19:0] OFD_INSN_RST = 20'h00000;
    localparam logic [31:0] OFD_WORD_RST = 32'h00000000;
    localparam logic [4:0] OFD_FLAGS_RST = 5'h00;

    // ********************************************************
    // instruction field positions
    // ********************************************************
    localparam int OFD_RM_LSB = 0;
    localparam int OFD_REG_LSB = 3;
    localparam int OFD_MOD_LSB = 6;
    localparam int OFD_BASE_LSB = 8;
    localparam int OFD_IDX_LSB = 11;
    localparam int OFD_SS_LSB = 14;
    localparam int OFD_TTTN_LSB = 16;

    // ********************************************************
    // field codes
    // ********************************************************
    localparam logic [1:0] OFD_MOD_NODISP = 2'h0;
    localparam logic [1:0] OFD_MOD_DISP8 = 2'h1;
    localparam logic [1:0] OFD_MOD_DISP32 = 2'h2;
    localparam logic [1:0] OFD_MOD_REG = 2'h3;
    localparam logic [2:0] OFD_RM_SIB = 3'h4;
    localparam logic [2:0] OFD_RM_ABS = 3'h5;
    localparam logic [2:0] OFD_RM16_ABS = 3'h6;
    localparam logic [2:0] OFD_IDX_NONE = 3'h4;
    localparam logic [1:0] OFD_SS_X1 = 2'h0;

    // register numbers
    localparam logic [2:0] OFD_BX_REG = 3'h3;
    localparam logic [2:0] OFD_STACK_POINTER_REG = 3'h4;
    localparam logic [2:0] OFD_FRAME_BASE_REG = 3'h5;
    localparam logic [2:0] OFD_SI_REG = 3'h6;
    localparam logic [2:0] OFD_DI_REG = 3'h7;

    // displacement sizes
    localparam logic [1:0] OFD_DSZ_NONE = 2'h0;
    localparam logic [1:0] OFD_DSZ_BYTE = 2'h1;
    localparam logic [1:0] OFD_DSZ_WORD = 2'h2;
    localparam logic [1:0] OFD_DSZ_DWORD = 2'h3;

    // operand widths
    localparam logic [1:0] OFD_WID_BYTE = 2'h0;
    localparam logic [1:0] OFD_WID_WORD = 2'h1;
    localparam logic [1:0] OFD_WID_DWORD = 2'h2;

    // condition selectors (upper three bits of tttn)
    localparam logic [2:0] OFD_CC_OVERFLOW = 3'h0;
    localparam logic [2:0] OFD_CC_BELOW = 3'h1;
    localparam logic [2:0] OFD_CC_ZERO = 3'h2;
    localparam logic [2:0] OFD_CC_BELOW_EQ = 3'h3;
    localparam logic [2:0] OFD_CC_SIGN = 3'h4;
    localparam logic [2:0] OFD_CC_PARITY = 3'h5;
    localparam logic [2:0] OFD_CC_LESS = 3'h6;
    localparam logic [2:0] OFD_CC_LESS_EQ = 3'h7;

    // flag positions in the flags register
    localparam int OFD_FLG_CF = 0;
    localparam int OFD_FLG_ZF = 1;
    localparam int OFD_FLG_SF = 2;
    localparam int OFD_FLG_OF = 3;
    localparam int OFD_FLG_PF = 4;

endpackage

// ---- rtl/ofd_cond_eval.sv ----
`timescale 1ns/1ps
`default_nettype none

module ofd_cond_eval
    import ofd_pkg::*;
(
    input wire logic [3:0] tttn,
    input wire logic [4:0] flags,
    output logic cond_true
);

    // ********************************************************
    // condition evaluation
    // ********************************************************
    logic base_cond;

    // signed less is sign differing from overflow
    wire less = flags[OFD_FLG_SF] ^ flags[OFD_FLG_OF];

    // pick the plain condition by selector
    always_comb begin
        case (tttn[3:1])
            OFD_CC_OVERFLOW: base_cond = flags[OFD_FLG_OF];
            OFD_CC_BELOW: base_cond = flags[OFD_FLG_CF];
            OFD_CC_ZERO: base_cond = flags[OFD_FLG_ZF];
            OFD_CC_BELOW_EQ: base_cond = flags[OFD_FLG_CF] | flags[OFD_FLG_ZF];
            OFD_CC_SIGN: base_cond = flags[OFD_FLG_SF];
            OFD_CC_PARITY: base_cond = flags[OFD_FLG_PF];
            OFD_CC_LESS: base_cond = less;
            OFD_CC_LESS_EQ: base_cond = less | flags[OFD_FLG_ZF];
            default: base_cond = 1'b0;
        endcase
    end

    // low bit set means the negated condition
    assign cond_true = base_cond ^ tttn[0];

endmodule

`default_nettype wire

// ---- dv/ofd_top_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****
// decode and bus checks
// ****
module ofd_top_checker
    import ofd_pkg::*;
(
    input wire logic REF_CLK,
    input wire logic RST_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PRDATA,
    input wire logic PSLVERR,
    input wire logic EA_BASE_VALID,
    input wire logic [2:0] EA_BASE_REG,
    input wire logic EA_INDEX_VALID,
    input wire logic [2:0] EA_INDEX_REG,
    input wire logic [1:0] EA_SCALE,
    input wire logic EA_STACK_SEG,
    input wire logic EA_UNDEFINED,
    input wire logic SIB_NEEDED,
    input wire logic OPND_IS_REG,
    input wire logic DST_IN_MEM,
    input wire logic SRC_IN_MEM
);
    // off-word or past the extended immediate word is unmapped
    wire logic unmapped = (PADDR[1:0] != 2'h0) || (PADDR > OFD_OFF_IMM_EXT);
    wire logic rd_setup = PSEL && !PENABLE && !PWRITE;
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_N);
    // the decode outputs share one register stage; PSLVERR is combinational
    err_map_a: assert property (PSLVERR == (PSEL && PENABLE && unmapped)) else $error("slave error mismatch");
    rdata_hold_a: assert property (!rd_setup |=> $stable(PRDATA)) else $error("read data moved");
    scale_sib_a: assert property (!SIB_NEEDED |-> EA_SCALE == 2'h0) else $error("scale without sib");
    reg_nomem_a: assert property (OPND_IS_REG |-> !EA_BASE_VALID && !EA_INDEX_VALID && !DST_IN_MEM
        && !SRC_IN_MEM) else $error("register operand uses memory");
    index_none_a: assert property (SIB_NEEDED && EA_INDEX_VALID |-> EA_INDEX_REG != OFD_IDX_NONE)
        else $error("index code 100 used");
    undef_flag_a: assert property (EA_UNDEFINED |-> SIB_NEEDED && !EA_INDEX_VALID
        && EA_SCALE != 2'h0) else $error("undefined flag wrong");
    stack_base_a: assert property (EA_STACK_SEG |-> EA_BASE_VALID
        && EA_BASE_REG inside {3'h4, 3'h5}) else $error("stack segment without stack base");
    mem_side_a: assert property (DST_IN_MEM |-> !SRC_IN_MEM && !OPND_IS_REG)
        else $error("both operands in memory");
    cover property (SIB_NEEDED && EA_INDEX_VALID);
    cover property (EA_UNDEFINED);
    cover property (PSLVERR);
endmodule
bind ofd_top ofd_top_checker chk (
    .REF_CLK(REF_CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PRDATA(PRDATA), .PSLVERR(PSLVERR), .EA_BASE_VALID(EA_BASE_VALID), .EA_BASE_REG(EA_BASE_REG),
    .EA_INDEX_VALID(EA_INDEX_VALID), .EA_INDEX_REG(EA_INDEX_REG), .EA_SCALE(EA_SCALE),
    .EA_STACK_SEG(EA_STACK_SEG), .EA_UNDEFINED(EA_UNDEFINED), .SIB_NEEDED(SIB_NEEDED),
    .OPND_IS_REG(OPND_IS_REG), .DST_IN_MEM(DST_IN_MEM), .SRC_IN_MEM(SRC_IN_MEM)
);
`default_nettype wire

// ---- dv/ofd_apb_host.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****
// bus master model
// ****
module ofd_apb_host (
    input wire logic clk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    // idle bus at time zero
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h00000000;
    end
    // one transfer; the watchdog cuts a hang
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                        output logic [31:0] rd, output logic err);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // released lines show the inverse so stale data cannot pass
        paddr <= ~a;
        pwdata <= ~wd;
    endtask
endmodule
`default_nettype wire

// ---- dv/test_operand_field_decoder.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****
// decoder bench
// ****
module test_operand_field_decoder import ofd_pkg::*; ();
    typedef struct packed {
        logic [7:0] c; logic [19:0] i; logic [31:0] d, m; logic [7:0] f;
        logic [15:0] ea, op; logic [31:0] xd, xm;
    } ofd_row_s;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    wire logic psel, penable, pwrite, pready, pslverr, cond_true;
    wire logic [7:0] paddr;
    wire logic [31:0] pwdata, prdata, ea_disp, imm_data;
    int bad_count = 0;
    int tests_run = 0;
    logic [31:0] v;
    logic err;
    logic [15:0] msk;
    wire logic [9:0] ea_o;
    wire logic [11:0] op_o;
    // ctrl, insn, disp, imm, flags, status words, extended disp, extended imm; row 8 breaks scale
    ofd_row_s rows [12] = '{
        '{8'h07, 20'h00053, 32'h000000F0, 32'h12345678, 8'h08, 16'h0407, 16'h2623, 32'hFFFFFFF0, 32'h12345678},
        '{8'h0F, 20'h10005, 32'h89ABCDEF, 32'h000000FF, 8'h00, 16'h0C00, 16'h2A50, 32'h89ABCDEF, 32'h000000FF},
        '{8'h07, 20'h00085, 32'h00000080, 32'h0, 8'h00, 16'h1C0B, 16'h0605, 32'h00000080, 32'h0},
        '{8'h07, 20'h2F044, 32'h0000007F, 32'h0, 8'h01, 16'h27D1, 16'h2604, 32'h0000007F, 32'h0},
        '{8'h07, 20'h44D04, 32'h11223344, 32'h0, 8'h02, 16'h2D30, 16'h2604, 32'h11223344, 32'h0},
        '{8'h07, 20'h62484, 32'h00000005, 32'h0, 8'h00, 16'h3C09, 16'h0604, 32'h00000005, 32'h0},
        '{8'h07, 20'h89544, 32'h00000080, 32'h0, 8'h04, 16'h365B, 16'h2604, 32'hFFFFFF80, 32'h0},
        '{8'h07, 20'hA6004, 32'h00000099, 32'h0, 8'h10, 16'hA101, 16'h2604, 32'h0, 32'h0},
        '{8'h3F, 20'hC00FC, 32'h0, 32'h00000085, 8'h04, 16'h4000, 16'h3247, 32'h0, 32'hFFFFFF85},
        '{8'h31, 20'hE00F1, 32'h0, 32'h1234ABCD, 8'h02, 16'h4000, 16'h20A1, 32'h0, 32'h000000CD},
        '{8'h15, 20'hF00F1, 32'h0, 32'hABCD1234, 8'h0C, 16'h4000, 16'h2161, 32'h0, 32'h00001234},
        '{8'h06, 20'h30046, 32'h00000090, 32'h0, 8'h00, 16'h140B, 16'h2606, 32'hFFFFFF90, 32'h0}};
    // condition results for flags CF, SF and PF set, by selector
    logic [7:0] cc_tab = 8'hFA;
    ofd_apb_host host (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    ofd_top dut (.REF_CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .EA_BASE_VALID(ea_o[0]), .EA_BASE_REG(ea_o[3:1]), .EA_INDEX_VALID(ea_o[4]), .EA_INDEX_REG(ea_o[7:5]),
        .EA_SCALE(ea_o[9:8]), .EA_DISP(ea_disp), .EA_STACK_SEG(), .EA_UNDEFINED(), .SIB_NEEDED(), .OPND_IS_REG(),
        .DST_REG(op_o[2:0]), .DST_HIGH_BYTE(op_o[3]), .DST_IN_MEM(op_o[10]), .SRC_REG(op_o[6:4]),
        .SRC_HIGH_BYTE(op_o[7]), .SRC_IN_MEM(op_o[11]), .OPND_WIDTH(op_o[9:8]),
        .IMM_DATA(imm_data), .COND_TRUE(cond_true));
    initial forever #10 clk = ~clk;
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        host.xfer(1'b1, a, d, v, err);
    endtask
    task automatic rdr(input logic [7:0] a);
        host.xfer(1'b0, a, 32'h0, v, err);
    endtask
    task automatic finish_test;
        $display("mismatches %0d of %0d comparisons", bad_count, tests_run);
        if (bad_count == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // main sequence: table rows, then hand-written cases
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rdr(OFD_OFF_DEC_EA);
        check(v, 32'h000000D7);
        foreach (rows[k]) begin
            wr(OFD_OFF_CTRL, {24'h0, rows[k].c});
            wr(OFD_OFF_INSN, {12'h0, rows[k].i});
            wr(OFD_OFF_DISP, rows[k].d);
            wr(OFD_OFF_IMM, rows[k].m);
            wr(OFD_OFF_FLAGS, {24'h0, rows[k].f});
            // register numbers of unused base or index are don't-care
            msk = 16'hFFFF;
            if (!rows[k].ea[0]) msk[3:1] = 3'h0;
            if (!rows[k].ea[4]) msk[7:5] = 3'h0;
            rdr(OFD_OFF_DEC_EA);
            check(v & {16'h0, msk}, {16'h0, rows[k].ea & msk});
            check(ea_o & msk, rows[k].ea & msk & 16'h3FF);
            msk = 16'hFFFF;
            if (rows[k].op[10]) msk[2:0] = 3'h0;
            if (rows[k].op[11]) msk[6:4] = 3'h0;
            rdr(OFD_OFF_DEC_OPND);
            check(v & {16'h0, msk}, {16'h0, rows[k].op & msk});
            check(ea_disp, rows[k].xd);
            check(imm_data, rows[k].xm);
            check(op_o & msk, rows[k].op & msk & 16'hFFF);
            check({31'h0, cond_true}, {31'h0, rows[k].op[13]});
        end
        wr(OFD_OFF_FLAGS, 32'h00000015);
        for (int t = 0; t < 16; t++) begin
            wr(OFD_OFF_INSN, {12'h0, t[3:0], 16'h0});
            rdr(OFD_OFF_DEC_OPND);
            check({31'h0, v[13]}, {31'h0, cc_tab[t[3:1]] ^ t[0]});
        end
        // unmapped read and a write to a read-only word
        rdr(8'h24);
        check({31'h0, err}, 32'h00000001);
        check(v, 32'h00000000);
        wr(OFD_OFF_DEC_EA, 32'hFFFFFFFF);
        check({31'h0, err}, 32'h00000000);
        rdr(OFD_OFF_DEC_EA);
        check(v, 32'h000000D7);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rdr(OFD_OFF_CTRL);
        check(v, 32'h00000000);
        rdr(OFD_OFF_FLAGS);
        check(v, 32'h00000000);
        finish_test;
    end
    // watchdog: the sequence needs well under two thousand cycles
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        finish_test;
    end
endmodule
`default_nettype wire
